// ### hw/flash_if_pkg.sv
/*
  Shared constants and types for the multi-I/O serial flash interface.
  Assumes a single interface module imports nothing and uses scoped names.
*/
`default_nettype none
package flash_if_pkg;
  // Command opcodes; the values are a local choice.
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_DDR_FAST_READ = 8'h0D;
  localparam logic [7:0] OP_DDR_DUAL_READ = 8'hBD;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] OP_REGISTER_WRITE = 8'h01;
  // Field layout of the configuration register.
  localparam int CFG_QUAD_BIT = 1;
  localparam int CFG_LAT_LSB = 6;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Dummy cycles for each latency code.
  localparam logic [3:0] LAT_CODE0 = 4'h8;
  localparam logic [3:0] LAT_CODE1 = 4'h4;
  localparam logic [3:0] LAT_CODE2 = 4'h2;
  localparam logic [3:0] LAT_CODE3 = 4'h0;
  // Frame geometry.
  localparam int INSTR_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int MODE_BITS = 8;
  localparam int BYTE_BITS = 8;

  typedef enum {
    FMT_STANDALONE, FMT_READ, FMT_FAST, FMT_DUAL_OUT, FMT_QUAD_OUT,
    FMT_DUAL_IO, FMT_QUAD_IO, FMT_DDR_SINGLE, FMT_DDR_DUAL,
    FMT_PROGRAM, FMT_QUAD_PROGRAM, FMT_ERASE, FMT_REG_WRITE
  } fmt_t;

  typedef enum {
    ST_STANDBY, ST_INSTR, ST_SINGLE_IN, ST_DUAL_IN, ST_QUAD_IN, ST_DDR_IN,
    ST_DATA_IN, ST_LATENCY, ST_SINGLE_OUT, ST_DUAL_OUT, ST_QUAD_OUT,
    ST_DDR_LATENCY, ST_IGNORE
  } state_t;
endpackage
`default_nettype wire

// ### hw/flash_if.sv
/*
  Device-side interface state machine of a multi-I/O serial flash, with a
  small page array standing in for the memory core. Assumes a host that
  drives select, serial clock and the I/O lines, and core logic on CLK_I.
*/
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Select high: standby, inputs ignored.
// - Eight instruction bits, MSB first, rising.
// - Write-protect only during register-write instruction.
// - Instruction picks transfer format.
// - Pause pin low suspends when not quad.
// - Pause: IO0/IO1 inputs ignored, outputs floated.
// - Pause release resumes the same state.
// - Quad mode: pin is IO3; DDR ignores pause.
// - Single input: IO0 only, no drive.
// - Latency code sets dummy cycle count.
// - Latency: inputs ignored, drivers off.
// - Single output on IO1 until deselect.
// - Dual I/O address, then latency or output.
// - Dual output two bits per cycle.
// - Quad program/quad output read address on IO0.
// - Quad input four bits per cycle.
// - Quad latency then four-bit output.
// - DDR single: IO0 both edges, then latency.
// - DDR dual: IO0/IO1 both edges, then latency.
// - Quad bit enables quad commands.
// - Program/erase/write need pulse count multiple eight.
module flash_if #(
  parameter int PAGE_AW = 4
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic [3:0] IO_I,
  output logic [3:0] IO_O,
  output logic [3:0] IO_OE_O,
  output logic CMD_VALID_O,
  output logic CMD_EXEC_O,
  output logic [7:0] CMD_OPCODE_O,
  output logic [23:0] CMD_ADDR_O,
  output logic QUAD_EN_O,
  output logic [1:0] LAT_CODE_O
);
  typedef logic [31:0] word_t;

  function automatic flash_if_pkg::fmt_t decode(input logic [7:0] op);
    flash_if_pkg::fmt_t f;
    f = flash_if_pkg::FMT_STANDALONE;
    case (op)
      flash_if_pkg::OP_READ: f = flash_if_pkg::FMT_READ;
      flash_if_pkg::OP_FAST_READ: f = flash_if_pkg::FMT_FAST;
      flash_if_pkg::OP_DUAL_OUT_READ: f = flash_if_pkg::FMT_DUAL_OUT;
      flash_if_pkg::OP_QUAD_OUT_READ: f = flash_if_pkg::FMT_QUAD_OUT;
      flash_if_pkg::OP_DUAL_IO_READ: f = flash_if_pkg::FMT_DUAL_IO;
      flash_if_pkg::OP_QUAD_IO_READ: f = flash_if_pkg::FMT_QUAD_IO;
      flash_if_pkg::OP_DDR_FAST_READ: f = flash_if_pkg::FMT_DDR_SINGLE;
      flash_if_pkg::OP_DDR_DUAL_READ: f = flash_if_pkg::FMT_DDR_DUAL;
      flash_if_pkg::OP_PAGE_PROGRAM: f = flash_if_pkg::FMT_PROGRAM;
      flash_if_pkg::OP_QUAD_PAGE_PROGRAM: f = flash_if_pkg::FMT_QUAD_PROGRAM;
      flash_if_pkg::OP_SECTOR_ERASE: f = flash_if_pkg::FMT_ERASE;
      flash_if_pkg::OP_REGISTER_WRITE: f = flash_if_pkg::FMT_REG_WRITE;
      default: f = flash_if_pkg::FMT_STANDALONE;
    endcase
    return f;
  endfunction

  function automatic word_t shift_in(input word_t sr, input logic [3:0] bits,
                                     input logic [2:0] w);
    word_t r;
    r = sr;
    case (w)
      3'h1: r = {sr[30:0], bits[0]};
      3'h2: r = {sr[29:0], bits[1:0]};
      3'h4: r = {sr[27:0], bits[3:0]};
      default: r = sr;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] lat_cycles(input logic [1:0] code);
    logic [3:0] n;
    n = flash_if_pkg::LAT_CODE0;
    case (code)
      2'h1: n = flash_if_pkg::LAT_CODE1;
      2'h2: n = flash_if_pkg::LAT_CODE2;
      2'h3: n = flash_if_pkg::LAT_CODE3;
      default: n = flash_if_pkg::LAT_CODE0;
    endcase
    return n;
  endfunction

  // Core clock domain: reset, configuration, select synchroniser.
  logic core_rst_reg;
  logic [7:0] config_reg_one;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  // Link clock domain.
  flash_if_pkg::state_t state_reg, state_next;
  flash_if_pkg::fmt_t fmt_reg, fmt_next;
  logic [5:0] bit_cnt_reg, bit_cnt_next;
  logic [3:0] lat_cnt_reg, lat_cnt_next;
  logic quad_s1_reg, quad_s2_reg;
  logic [1:0] lat_s1_reg, lat_s2_reg;
  word_t in_sr_reg, in_sr_next;
  logic [15:0] pulse_cnt_reg;
  logic [7:0] opcode_reg;
  logic [23:0] addr_reg;
  logic [7:0] data_byte_reg;
  logic wp_low_reg;
  flash_if_pkg::fmt_t frame_fmt_reg;
  logic [PAGE_AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [7:0] page_mem [0:(1<<PAGE_AW)-1];
  logic [3:0] neg_bits_reg;
  logic [3:0] io_out_reg;
  logic [7:0] out_sr_reg;
  logic [3:0] out_cnt_reg;
  logic out_started_reg;

  // The select pin resets the link logic asynchronously: the serial clock
  // does not run outside a frame, so nothing could step back to standby.
  // select resets link
  wire rst_sck = CS_N_I | core_rst_reg;
  wire is_ddr = (fmt_reg == flash_if_pkg::FMT_DDR_SINGLE) ||
                (fmt_reg == flash_if_pkg::FMT_DDR_DUAL);
  wire paused = !quad_s2_reg && !IO_I[3] && !is_ddr &&
                (state_reg != flash_if_pkg::ST_STANDBY);
  wire in_instr = (state_reg == flash_if_pkg::ST_STANDBY) ||
                  (state_reg == flash_if_pkg::ST_INSTR);
  wire has_mode = (fmt_reg == flash_if_pkg::FMT_DUAL_IO) ||
                  (fmt_reg == flash_if_pkg::FMT_QUAD_IO) || is_ddr;
  wire [5:0] addr_target = has_mode ?
      6'(flash_if_pkg::ADDR_BITS + flash_if_pkg::MODE_BITS) :
      6'(flash_if_pkg::ADDR_BITS);
  wire [3:0] lat_sel = lat_cycles(lat_s2_reg);
  wire [2:0] in_w = (state_reg == flash_if_pkg::ST_DUAL_IN) ? 3'h2 :
                    (state_reg == flash_if_pkg::ST_QUAD_IN) ? 3'h4 :
                    ((state_reg == flash_if_pkg::ST_DDR_IN) &&
                     (fmt_reg == flash_if_pkg::FMT_DDR_DUAL)) ? 3'h2 : 3'h1;
  wire [2:0] out_w = (state_reg == flash_if_pkg::ST_DUAL_OUT) ? 3'h2 :
                     (state_reg == flash_if_pkg::ST_QUAD_OUT) ? 3'h4 : 3'h1;
  wire [2:0] ddr_w = (fmt_reg == flash_if_pkg::FMT_DDR_DUAL) ? 3'h2 : 3'h1;
  wire [5:0] ddr_add = (bit_cnt_reg == 6'h00) ? 6'(ddr_w) : 6'(ddr_w + ddr_w);
  wire [7:0] opcode_now = {in_sr_reg[6:0], IO_I[0]};
  flash_if_pkg::fmt_t fmt_now;
  assign fmt_now = decode(opcode_now);
  wire [23:0] addr_now = has_mode ? in_sr_next[31:8] : in_sr_next[23:0];
  wire is_prog_class = (fmt_reg == flash_if_pkg::FMT_PROGRAM) ||
                       (fmt_reg == flash_if_pkg::FMT_QUAD_PROGRAM);

  // Next-state logic of the link state machine.
  always_comb begin
    state_next = state_reg;
    fmt_next = fmt_reg;
    bit_cnt_next = bit_cnt_reg;
    lat_cnt_next = lat_cnt_reg;
    in_sr_next = in_sr_reg;
    case (state_reg)
      flash_if_pkg::ST_STANDBY, flash_if_pkg::ST_INSTR: begin
        in_sr_next = shift_in(in_sr_reg, IO_I, 3'h1);
        bit_cnt_next = (state_reg == flash_if_pkg::ST_STANDBY) ? 6'h01 : bit_cnt_reg + 6'h01;
        state_next = flash_if_pkg::ST_INSTR;
        if (bit_cnt_next == 6'(flash_if_pkg::INSTR_BITS)) begin
          bit_cnt_next = 6'h00;
          fmt_next = fmt_now;
          case (fmt_now)
            flash_if_pkg::FMT_STANDALONE: state_next = flash_if_pkg::ST_IGNORE;
            flash_if_pkg::FMT_DUAL_IO: state_next = flash_if_pkg::ST_DUAL_IN;
            flash_if_pkg::FMT_QUAD_IO:
              state_next = quad_s2_reg ? flash_if_pkg::ST_QUAD_IN : flash_if_pkg::ST_IGNORE;
            flash_if_pkg::FMT_QUAD_OUT, flash_if_pkg::FMT_QUAD_PROGRAM:
              state_next = quad_s2_reg ? flash_if_pkg::ST_SINGLE_IN : flash_if_pkg::ST_IGNORE;
            flash_if_pkg::FMT_DDR_SINGLE, flash_if_pkg::FMT_DDR_DUAL:
              state_next = flash_if_pkg::ST_DDR_IN;
            flash_if_pkg::FMT_REG_WRITE: state_next = flash_if_pkg::ST_DATA_IN;
            default: state_next = flash_if_pkg::ST_SINGLE_IN;
          endcase
        end
      end
      flash_if_pkg::ST_SINGLE_IN, flash_if_pkg::ST_DUAL_IN, flash_if_pkg::ST_QUAD_IN: begin
        in_sr_next = shift_in(in_sr_reg, IO_I, in_w);
        bit_cnt_next = bit_cnt_reg + 6'(in_w);
        if (bit_cnt_next == addr_target) begin
          bit_cnt_next = 6'h00;
          lat_cnt_next = lat_sel;
          case (fmt_reg)
            flash_if_pkg::FMT_READ: state_next = flash_if_pkg::ST_SINGLE_OUT;
            flash_if_pkg::FMT_PROGRAM, flash_if_pkg::FMT_QUAD_PROGRAM:
              state_next = flash_if_pkg::ST_DATA_IN;
            flash_if_pkg::FMT_ERASE: state_next = flash_if_pkg::ST_IGNORE;
            default:
              state_next = (lat_sel == 4'h0) ? flash_if_pkg::ST_SINGLE_OUT : flash_if_pkg::ST_LATENCY;
          endcase
          if ((lat_sel == 4'h0) && (fmt_reg == flash_if_pkg::FMT_DUAL_OUT ||
                                   fmt_reg == flash_if_pkg::FMT_DUAL_IO))
            state_next = flash_if_pkg::ST_DUAL_OUT;
          if ((lat_sel == 4'h0) && (fmt_reg == flash_if_pkg::FMT_QUAD_OUT ||
                                   fmt_reg == flash_if_pkg::FMT_QUAD_IO))
            state_next = flash_if_pkg::ST_QUAD_OUT;
        end
      end
      flash_if_pkg::ST_DDR_IN: begin
        in_sr_next = (bit_cnt_reg == 6'h00) ? in_sr_reg :
                     shift_in(in_sr_reg, neg_bits_reg, ddr_w);
        in_sr_next = shift_in(in_sr_next, IO_I, ddr_w);
        bit_cnt_next = bit_cnt_reg + ddr_add;
        if (bit_cnt_next + 6'(ddr_w) == addr_target)
          state_next = flash_if_pkg::ST_DDR_LATENCY;
      end
      flash_if_pkg::ST_DDR_LATENCY: begin
        if (bit_cnt_reg != 6'h00)
          in_sr_next = shift_in(in_sr_reg, neg_bits_reg, ddr_w);
        bit_cnt_next = 6'h00;
      end
      flash_if_pkg::ST_DATA_IN: begin
        in_sr_next = shift_in(in_sr_reg, IO_I,
                              (fmt_reg == flash_if_pkg::FMT_QUAD_PROGRAM) ? 3'h4 : 3'h1);
      end
      flash_if_pkg::ST_LATENCY: begin
        lat_cnt_next = lat_cnt_reg - 4'h1;
        if (lat_cnt_reg == 4'h1) begin
          case (fmt_reg)
            flash_if_pkg::FMT_DUAL_OUT, flash_if_pkg::FMT_DUAL_IO:
              state_next = flash_if_pkg::ST_DUAL_OUT;
            flash_if_pkg::FMT_QUAD_OUT, flash_if_pkg::FMT_QUAD_IO:
              state_next = flash_if_pkg::ST_QUAD_OUT;
            default: state_next = flash_if_pkg::ST_SINGLE_OUT;
          endcase
        end
      end
      default: state_next = state_reg;
    endcase
  end

  always_ff @(posedge SCK_I or posedge rst_sck) begin
    if (rst_sck) begin
      state_reg <= flash_if_pkg::ST_STANDBY;
      fmt_reg <= flash_if_pkg::FMT_STANDALONE;
      bit_cnt_reg <= 6'h00;
      lat_cnt_reg <= 4'h0;
    end else if (!paused) begin
      state_reg <= state_next;
      fmt_reg <= fmt_next;
      bit_cnt_reg <= bit_cnt_next;
      lat_cnt_reg <= lat_cnt_next;
    end
  end

  // Capture registers outlive the frame so the core domain can read them
  // once select has gone high and the serial clock has stopped.
  always_ff @(posedge SCK_I or posedge core_rst_reg) begin
    if (core_rst_reg) begin
      in_sr_reg <= 32'h00000000;
      pulse_cnt_reg <= 16'h0000;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
      data_byte_reg <= 8'h00;
      wp_low_reg <= 1'b0;
      frame_fmt_reg <= flash_if_pkg::FMT_STANDALONE;
      quad_s1_reg <= 1'b0;
      quad_s2_reg <= 1'b0;
      lat_s1_reg <= 2'h0;
      lat_s2_reg <= 2'h0;
    end else begin
      quad_s1_reg <= config_reg_one[flash_if_pkg::CFG_QUAD_BIT];
      quad_s2_reg <= quad_s1_reg;
      lat_s1_reg <= config_reg_one[flash_if_pkg::CFG_LAT_LSB +: 2];
      lat_s2_reg <= lat_s1_reg;
      if (!CS_N_I && !paused) begin
        in_sr_reg <= in_sr_next;
        pulse_cnt_reg <= (state_reg == flash_if_pkg::ST_STANDBY) ? 16'h0001 :
                         pulse_cnt_reg + 16'h0001;
        if (state_reg == flash_if_pkg::ST_STANDBY)
          wp_low_reg <= !quad_s2_reg && !IO_I[2];
        else if (in_instr && !quad_s2_reg && !IO_I[2])
          wp_low_reg <= 1'b1;
        if (in_instr && fmt_next != fmt_reg)
          opcode_reg <= opcode_now;
        if (in_instr && bit_cnt_next == 6'h00)
          opcode_reg <= opcode_now;
        // The frame format outlives the select reset; refused quad commands count as none.
        if (state_reg == flash_if_pkg::ST_STANDBY)
          frame_fmt_reg <= flash_if_pkg::FMT_STANDALONE;
        else if (in_instr && bit_cnt_next == 6'h00)
          frame_fmt_reg <= (state_next == flash_if_pkg::ST_IGNORE) ?
                           flash_if_pkg::FMT_STANDALONE : fmt_next;
        if ((state_reg == flash_if_pkg::ST_SINGLE_IN || state_reg == flash_if_pkg::ST_DUAL_IN ||
             state_reg == flash_if_pkg::ST_QUAD_IN) && bit_cnt_next == 6'h00)
          addr_reg <= addr_now;
        if (state_reg == flash_if_pkg::ST_DDR_LATENCY && bit_cnt_reg != 6'h00)
          addr_reg <= in_sr_next[31:8];
        if (state_reg == flash_if_pkg::ST_DATA_IN)
          data_byte_reg <= in_sr_next[7:0];
      end
    end
  end

  wire byte_done = (fmt_reg == flash_if_pkg::FMT_QUAD_PROGRAM) ? pulse_cnt_reg[0] :
                   (pulse_cnt_reg[2:0] == 3'h7);
  // Page array: program data lands here and reads return it.
  always_ff @(posedge SCK_I) begin
    if (state_reg != flash_if_pkg::ST_DATA_IN)
      wr_ptr_reg <= addr_now[PAGE_AW-1:0];
    else if (!paused && is_prog_class && byte_done && !CS_N_I) begin
      page_mem[wr_ptr_reg] <= in_sr_next[7:0];
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  wire out_state = (state_reg == flash_if_pkg::ST_SINGLE_OUT) ||
                   (state_reg == flash_if_pkg::ST_DUAL_OUT) ||
                   (state_reg == flash_if_pkg::ST_QUAD_OUT);
  wire [PAGE_AW-1:0] rd_idx = out_started_reg ? rd_ptr_reg : addr_reg[PAGE_AW-1:0];
  wire [7:0] fresh_byte = page_mem[rd_idx];
  wire [7:0] src_byte = (out_cnt_reg == 4'h0) ? fresh_byte : out_sr_reg;
  always_ff @(negedge SCK_I or posedge rst_sck) begin
    if (rst_sck) begin
      neg_bits_reg <= 4'h0;
      io_out_reg <= 4'h0;
      out_sr_reg <= 8'h00;
      out_cnt_reg <= 4'h0;
      out_started_reg <= 1'b0;
      rd_ptr_reg <= '0;
    end else if (!paused) begin
      neg_bits_reg <= IO_I;
      if (out_state) begin
        out_started_reg <= 1'b1;
        out_sr_reg <= src_byte << out_w;
        out_cnt_reg <= ((out_cnt_reg == 4'h0) ? 4'h8 : out_cnt_reg) - 4'(out_w);
        if (out_cnt_reg == 4'h0)
          rd_ptr_reg <= rd_idx + 1'b1;
        case (out_w)
          3'h2: io_out_reg <= {2'h0, src_byte[7:6]};
          3'h4: io_out_reg <= src_byte[7:4];
          default: io_out_reg <= {2'h0, src_byte[7], 1'b0};
        endcase
      end
    end
  end

  wire [3:0] oe_state = (state_reg == flash_if_pkg::ST_SINGLE_OUT) ? 4'h2 :
                        (state_reg == flash_if_pkg::ST_DUAL_OUT) ? 4'h3 :
                        (state_reg == flash_if_pkg::ST_QUAD_OUT) ? 4'hF : 4'h0;
  assign IO_OE_O = paused ? 4'h0 : oe_state;
  assign IO_O = io_out_reg;

  // Core side: frame end is seen through the select synchroniser.
  wire frame_end = cs_s2_reg && !cs_s3_reg;
  // The live format is already reset by select here, so the captured one is used.
  wire needs_count = (frame_fmt_reg == flash_if_pkg::FMT_PROGRAM) ||
                     (frame_fmt_reg == flash_if_pkg::FMT_QUAD_PROGRAM) ||
                     (frame_fmt_reg == flash_if_pkg::FMT_ERASE) ||
                     (frame_fmt_reg == flash_if_pkg::FMT_REG_WRITE);
  wire exec_ok = needs_count && (pulse_cnt_reg[2:0] == 3'h0) &&
                 !((frame_fmt_reg == flash_if_pkg::FMT_REG_WRITE) && wp_low_reg);
  always_ff @(posedge CLK_I) begin
    core_rst_reg <= !RESETN_I;
    if (!RESETN_I) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      config_reg_one <= flash_if_pkg::CFG_RESET;
      CMD_VALID_O <= 1'b0;
      CMD_EXEC_O <= 1'b0;
      CMD_OPCODE_O <= 8'h00;
      CMD_ADDR_O <= 24'h000000;
    end else begin
      cs_s1_reg <= CS_N_I;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      CMD_VALID_O <= frame_end;
      CMD_EXEC_O <= frame_end && exec_ok;
      if (frame_end) begin
        CMD_OPCODE_O <= opcode_reg;
        CMD_ADDR_O <= addr_reg;
      end
      if (frame_end && exec_ok && frame_fmt_reg == flash_if_pkg::FMT_REG_WRITE)
        config_reg_one <= data_byte_reg;
    end
  end
  assign QUAD_EN_O = config_reg_one[flash_if_pkg::CFG_QUAD_BIT];
  assign LAT_CODE_O = config_reg_one[flash_if_pkg::CFG_LAT_LSB +: 2];

  // Link-domain checks.
  a_instr_eight: assert property (@(posedge SCK_I) disable iff (rst_sck)
    (state_reg == flash_if_pkg::ST_INSTR && bit_cnt_reg == 6'h07 && !paused)
      |=> (state_reg != flash_if_pkg::ST_INSTR))
    else $error("instruction not closed after eight bits");
  a_pause_hold: assert property (@(posedge SCK_I) disable iff (rst_sck)
    paused |=> (state_reg == $past(state_reg)))
    else $error("state moved while paused");
  a_pause_float: assert property (@(posedge SCK_I) disable iff (rst_sck)
    paused |-> (IO_OE_O[1:0] == 2'h0))
    else $error("IO0/IO1 driven while paused");
  a_latency_quiet: assert property (@(posedge SCK_I) disable iff (rst_sck)
    (state_reg == flash_if_pkg::ST_LATENCY || state_reg == flash_if_pkg::ST_DDR_LATENCY)
      |-> (IO_OE_O == 4'h0))
    else $error("driver on during latency");
  a_single_in_quiet: assert property (@(posedge SCK_I) disable iff (rst_sck)
    (state_reg == flash_if_pkg::ST_SINGLE_IN) |-> (IO_OE_O == 4'h0))
    else $error("driver on during single input");
  a_dual_out_drive: assert property (@(posedge SCK_I) disable iff (rst_sck)
    (state_reg == flash_if_pkg::ST_DUAL_OUT && !paused) |-> (IO_OE_O == 4'h3))
    else $error("dual output lanes wrong");
  a_quad_out_drive: assert property (@(posedge SCK_I) disable iff (rst_sck)
    (state_reg == flash_if_pkg::ST_QUAD_OUT) |-> (IO_OE_O == 4'hF))
    else $error("quad output lanes wrong");
  a_latency_length: assert property (@(posedge SCK_I) disable iff (rst_sck)
    (state_reg == flash_if_pkg::ST_LATENCY && lat_cnt_reg == 4'h2 && !paused)
      |=> (state_reg == flash_if_pkg::ST_LATENCY) ##1
          (paused || state_reg != flash_if_pkg::ST_LATENCY))
    else $error("latency count off");
  // Core-domain checks.
  a_exec_count: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CMD_EXEC_O |-> (pulse_cnt_reg[2:0] == 3'h0 && CMD_VALID_O))
    else $error("command executed with bad pulse count");
  a_standby_float: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    CS_N_I |-> (IO_OE_O == 4'h0))
    else $error("driving while deselected");
  c_quad_read: cover property (@(posedge SCK_I) state_reg == flash_if_pkg::ST_QUAD_OUT);
  c_pause: cover property (@(posedge SCK_I) paused && state_reg == flash_if_pkg::ST_SINGLE_OUT);
  c_ddr_done: cover property (@(posedge SCK_I) state_reg == flash_if_pkg::ST_DDR_LATENCY);
  c_reg_write: cover property (@(posedge CLK_I) CMD_EXEC_O && QUAD_EN_O);
endmodule
`default_nettype wire

// ### tb/spi_host.sv
/*
  Host controller model: drives select, the link clock and the I/O lines.
  Assumes the bench resolves each pin from the device's output enables alone.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_host (
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  input wire logic [3:0] io_i
);
  logic [3:0] drv = 4'hF;
  logic rel = 1'b0;
  // Released lines toggle so that a stale level can never pass for data.
  assign io_o = rel ? {drv[3:2], sck_o, ~sck_o} : drv;
  initial sck_o = 1'b0;
  initial cs_n_o = 1'b1;
  task automatic frame_start();
    #7 cs_n_o = 1'b0;
    #16;
  endtask
  task automatic put(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      drv[0] = v[i];
      #16 sck_o = 1'b1;
      #16 sck_o = 1'b0;
    end
  endtask
  task automatic idle(input int n, input logic r);
    rel = r;
    repeat (n) begin
      #16 sck_o = 1'b1;
      #16 sck_o = 1'b0;
    end
  endtask
  task automatic get(input int w, output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      #16 sck_o = 1'b1;
      b = (w == 4) ? {b[3:0], io_i} : (w == 2) ? {b[5:0], io_i[1:0]} : {b[6:0], io_i[1]};
      #16 sck_o = 1'b0;
    end
  endtask
  // Waits past the clock edge so that a pause level cannot race the falling edge.
  task automatic pin(input int k, input logic v);
    #2 drv[k] = v;
  endtask
  // Select rises after the last edge.
  task automatic frame_end();
    #16 cs_n_o = 1'b1;
    rel = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/multi_io_serial_flash_interface_states_test.sv
/*
  Self-checking bench for the flash interface state machine.
  Assumes the host model keeps the link clock still between frames.
*/
`timescale 1ns/10ps
`default_nettype none
module multi_io_serial_flash_interface_states_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  wire logic sck, cs_n, cmd_valid, cmd_exec, quad_en;
  wire logic [3:0] host_io, io_o, io_oe, io_wire;
  wire logic [7:0] cmd_opcode;
  wire logic [23:0] cmd_addr;
  wire logic [1:0] lat_code;
  logic [7:0] b;
  int num_errors = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  assign io_wire = (io_oe & io_o) | (~io_oe & host_io);
  spi_host host (.sck_o(sck), .cs_n_o(cs_n), .io_o(host_io), .io_i(io_wire));
  flash_if uut (.CLK_I(clk), .RESETN_I(resetn), .SCK_I(sck), .CS_N_I(cs_n), .IO_I(io_wire),
    .IO_O(io_o), .IO_OE_O(io_oe), .CMD_VALID_O(cmd_valid), .CMD_EXEC_O(cmd_exec),
    .CMD_OPCODE_O(cmd_opcode), .CMD_ADDR_O(cmd_addr), .QUAD_EN_O(quad_en),
    .LAT_CODE_O(lat_code));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_cmd(input logic exp_exec);
    int n;
    for (n = 0; n < 20 && cmd_valid !== 1'b1; n++) begin
      @(posedge clk);
      #2;
    end
    if (n == 20) begin
      num_errors++;
      give_verdict();
    end else begin
      chk(cmd_exec, exp_exec);
    end
  endtask
  task automatic test_program();
    host.frame_start();
    host.put({8'h02, 24'h000003}, 32);
    host.put(16'hA53C, 16);
    host.frame_end();
    wait_cmd(1'b1);
    chk(cmd_opcode, 8'h02);
    chk(cmd_addr, 24'h000003);
    $display("program test ended");
  endtask
  task automatic test_read_pause();
    host.frame_start();
    host.put(8'h03, 8);
    chk(io_oe, 4'h0);
    host.put(24'h000003, 24);
    host.get(1, b);
    chk(b, 8'hA5);
    host.pin(3, 1'b0);
    host.idle(2, 1'b0);
    chk(io_oe[1:0], 2'h0);
    host.pin(3, 1'b1);
    host.get(1, b);
    chk(b, 8'h3C);
    host.frame_end();
    wait_cmd(1'b0);
    $display("read and pause test ended");
  endtask
  task automatic test_dual();
    host.frame_start();
    host.put({8'h3B, 24'h000004}, 32);
    host.idle(1, 1'b1);
    chk(io_oe, 4'h0);
    host.idle(int'(flash_if_pkg::LAT_CODE0) - 1, 1'b1);
    host.get(2, b);
    chk(b, 8'h3C);
    host.frame_end();
    wait_cmd(1'b0);
    $display("dual read test ended");
  endtask
  task automatic test_erase_short();
    host.frame_start();
    host.put({8'hD8, 24'h000000}, 32);
    host.put(32'h1, 1);
    host.frame_end();
    wait_cmd(1'b0);
    $display("short erase test ended");
  endtask
  task automatic test_config();
    host.pin(2, 1'b0);
    host.frame_start();
    host.put(8'h01, 8);
    host.pin(2, 1'b1);
    host.put(16'h0042, 16);
    host.frame_end();
    wait_cmd(1'b0);
    host.frame_start();
    host.put({8'h01, 16'h0042}, 24);
    host.frame_end();
    wait_cmd(1'b1);
    chk(quad_en, 1'b1);
    chk(lat_code, 2'h1);
    $display("config test ended");
  endtask
  task automatic test_quad();
    host.pin(2, 1'b0);
    host.frame_start();
    host.put({8'h6B, 24'h000003}, 32);
    host.idle(1, 1'b1);
    chk(io_oe, 4'h0);
    host.idle(int'(flash_if_pkg::LAT_CODE1) - 1, 1'b1);
    host.get(4, b);
    chk(b, 8'hA5);
    chk(io_oe, 4'hF);
    host.frame_end();
    wait_cmd(1'b0);
    $display("quad read test ended");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #2 resetn = 1'b1;
    repeat (6) @(posedge clk);
    test_program();
    test_read_pause();
    test_dual();
    test_erase_short();
    test_config();
    test_quad();
    give_verdict();
  end
endmodule
`default_nettype wire
